// ---- pid_params.svh ----
// Constants shared by both ends of the protected identifier read link.
`ifndef PID_PARAMS_SVH
`define PID_PARAMS_SVH
`define PID_CTRL_CODE 7'h57
`define PID_DIR_WRITE 1'b0
`define PID_DIR_READ 1'b1
`define PID_BLK_FIRST 8'hf0
`define PID_BLK_LAST 8'hf7
`define PID_ID48_FIRST_IDX 3'h2
`define PID_ENCAP_FILL 16'hfffe
`define PID_ENCAP_RSVD 16'hffff
`define PID_ERASED 8'hff
`define PID_CLK_PERIOD_NS 25
// The three-stage input filters delay every edge by four cycles, so each
// quarter of the link clock needs four cycles for data to settle first.
`define PID_SCL_PERIOD_NS 400
`define PID_QUARTER_CYC ((`PID_SCL_PERIOD_NS / 4) / `PID_CLK_PERIOD_NS)
`define PID_FIFO_WIDTH 8
`define PID_FIFO_DEPTH 8
`endif

// ---- pid_pkg.sv ----
// Types shared by both ends of the protected identifier read link.
`default_nettype none
`include "pid_params.svh"
package pid_pkg;
    typedef enum logic [1:0] {
        PID_VAR_BLANK = 2'h0,
        PID_VAR_ID48 = 2'h1,
        PID_VAR_ID64 = 2'h2
    } pid_variant_t;

    typedef enum logic [2:0] {
        PID_D_IDLE = 3'h0,
        PID_D_CTRL = 3'h1,
        PID_D_ACK_CTRL = 3'h2,
        PID_D_WORD = 3'h3,
        PID_D_ACK_WORD = 3'h4,
        PID_D_SEND = 3'h5,
        PID_D_MACK = 3'h6
    } pid_dev_state_t;

    typedef enum logic [2:0] {
        PID_M_IDLE = 3'h0,
        PID_M_START = 3'h1,
        PID_M_TX = 3'h2,
        PID_M_RX = 3'h3,
        PID_M_STOP = 3'h4
    } pid_mst_state_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        pid_dev_state_t st;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic macked;
        logic sda_oe;
        logic byte_done;
    } pid_dev_t;

    typedef struct packed {
        logic [2:0] sda_s;
        logic sda_f;
        pid_mst_state_t st;
        logic [1:0] q;
        logic [3:0] qc;
        logic [3:0] slot;
        logic [1:0] step;
        logic [7:0] sh;
        logic [7:0] addr;
        logic [3:0] left;
        logic push;
        logic [7:0] pdata;
        logic scl_oe;
        logic sda_oe;
        logic cmd_ready;
        logic done;
        logic nack_err;
    } pid_mst_t;

    // Host-side widening of a six-byte identifier to eight bytes. [RULE13]
    function automatic logic [63:0] pid_encap48(input logic [47:0] id48);
        pid_encap48 = {id48[47:24], `PID_ENCAP_FILL, id48[23:0]};
    endfunction
endpackage
`default_nettype wire

// ---- pid_link_if.sv ----
// Two-wire link between the identifier store and the bus master.
`default_nettype none
interface pid_link_if;
    logic m_scl_oe;
    logic m_sda_oe;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires: any enable pulls the line low, otherwise it floats high.
    assign scl = ~m_scl_oe;
    assign sda = ~(m_sda_oe | d_sda_oe);

    modport dev (input scl, input sda, output d_sda_oe);
    modport mst (input scl, input sda, output m_scl_oe, output m_sda_oe);
endinterface
`default_nettype wire

// ---- pid_id_device.sv ----
// Protected identifier store: two-wire slave answering random and sequential reads.
//
// Summary of operation
// [RULE1] Write control byte then word address loads pointer.
// [RULE2] Repeated start after address keeps loaded pointer.
// [RULE3] Read control byte acknowledged, byte at pointer sent.
// [RULE4] Master NACK plus stop ends driving.
// [RULE5] After random read pointer is next location.
// [RULE6] Master acknowledge fetches next sequential byte.
// [RULE7] Pointer advances by one per byte.
// [RULE8] Pointer wraps from last to first block location.
// [RULE9] Six-byte identifier fills third through last location.
// [RULE10] Organization bytes first, then extension, ascending.
// [RULE11] Eight-byte identifier fills the whole block.
// [RULE12] Three organization bytes, then five extension bytes.
// [RULE13] Host inserts filler word to widen short identifier.
// [RULE14] Long extension never starts with reserved words.
// [RULE15] Answer only to own seven-bit address.
// [RULE16] Word address outside block is not acknowledged.
// [RULE17] One pointer shared with the clock register space.
`default_nettype none
`include "pid_params.svh"
module pid_id_device #(
    parameter pid_pkg::pid_variant_t VARIANT = pid_pkg::PID_VAR_ID64,
    // Arbitrary identifier values; real parts are programmed per unit.
    parameter logic [23:0] ORG_ID = 24'h5a3c1e,
    parameter logic [39:0] EXT_ID = 40'h0123456789
) (
    input wire logic clock,
    input wire logic resetn,
    pid_link_if.dev link,
    output logic [7:0] addr_ptr,
    output logic byte_done
);
    pid_pkg::pid_dev_t r;
    pid_pkg::pid_dev_t next_r;

    // ----------------------------------------------------------------
    // Identifier contents
    // ----------------------------------------------------------------
    function automatic logic [7:0] id_byte(input logic [2:0] idx);
        logic [39:0] ext;
        logic [63:0] id64;
        logic [47:0] id48;
        ext = EXT_ID;
        // A reserved leading word would be mistaken for a widened short
        // identifier, so the top byte is cleared to break the pattern.
        if (ext[39:24] == `PID_ENCAP_FILL || ext[39:24] == `PID_ENCAP_RSVD) begin // [RULE14]
            ext[39:32] = 8'h00;
        end
        id64 = {ORG_ID, ext}; // [RULE11] [RULE12]
        id48 = {ORG_ID, ext[23:0]}; // [RULE10]
        id_byte = `PID_ERASED;
        case (VARIANT)
            pid_pkg::PID_VAR_ID64: begin
                id_byte = id64[8 * (7 - int'(idx)) +: 8]; // [RULE11]
            end
            pid_pkg::PID_VAR_ID48: begin
                if (idx >= `PID_ID48_FIRST_IDX) begin // [RULE9]
                    id_byte = id48[8 * (7 - int'(idx)) +: 8];
                end
            end
            default: begin
                id_byte = `PID_ERASED;
            end
        endcase
    endfunction

    function automatic logic in_block(input logic [7:0] a);
        in_block = (a >= `PID_BLK_FIRST) && (a <= `PID_BLK_LAST);
    endfunction

    // The pointer may have been left anywhere by the clock register space;
    // outside the block the store returns erased data.
    function automatic logic [7:0] read_at(input logic [7:0] a);
        read_at = in_block(a) ? id_byte(a[2:0]) : `PID_ERASED; // [RULE17]
    endfunction

    function automatic logic [7:0] advance(input logic [7:0] a);
        advance = (a == `PID_BLK_LAST) ? `PID_BLK_FIRST : 8'(a + 8'h01); // [RULE7] [RULE8]
    endfunction

    // ----------------------------------------------------------------
    // Bus protocol engine
    // ----------------------------------------------------------------
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [7:0] b;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        b = 8'h00;
        next_r = r;
        next_r.byte_done = 1'b0;
        next_r.scl_s = {r.scl_s[1:0], link.scl};
        next_r.sda_s = {r.sda_s[1:0], link.sda};
        if (r.scl_s[1] == r.scl_s[2]) begin
            next_r.scl_f = r.scl_s[2];
        end
        if (r.sda_s[1] == r.sda_s[2]) begin
            next_r.sda_f = r.sda_s[2];
        end
        scl_rise = next_r.scl_f & ~r.scl_f;
        scl_fall = ~next_r.scl_f & r.scl_f;
        start_c = r.scl_f & next_r.scl_f & r.sda_f & ~next_r.sda_f;
        stop_c = r.scl_f & next_r.scl_f & ~r.sda_f & next_r.sda_f;
        if (start_c) begin
            // A repeated start leaves the pointer untouched. [RULE2]
            next_r.st = pid_pkg::PID_D_CTRL;
            next_r.bitcnt = 4'h0;
            next_r.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_r.st = pid_pkg::PID_D_IDLE;
            next_r.sda_oe = 1'b0; // [RULE4]
        end else begin
            case (r.st)
                pid_pkg::PID_D_IDLE: begin
                    next_r.sda_oe = 1'b0;
                end
                pid_pkg::PID_D_CTRL, pid_pkg::PID_D_WORD: begin
                    if (scl_rise && r.bitcnt < 4'h8) begin
                        next_r.sh = {r.sh[6:0], r.sda_f};
                        next_r.bitcnt = 4'(r.bitcnt + 4'h1);
                    end else if (scl_fall && r.bitcnt == 4'h8) begin
                        if (r.st == pid_pkg::PID_D_CTRL) begin
                            if (r.sh[7:1] == `PID_CTRL_CODE) begin // [RULE15]
                                next_r.rw = r.sh[0];
                                next_r.sda_oe = 1'b1;
                                next_r.st = pid_pkg::PID_D_ACK_CTRL;
                            end else begin
                                next_r.st = pid_pkg::PID_D_IDLE;
                            end
                        end else if (in_block(r.sh)) begin
                            next_r.ptr = r.sh; // [RULE1]
                            next_r.sda_oe = 1'b1;
                            next_r.st = pid_pkg::PID_D_ACK_WORD;
                        end else begin
                            next_r.st = pid_pkg::PID_D_IDLE; // [RULE16]
                        end
                    end
                end
                pid_pkg::PID_D_ACK_CTRL: begin
                    if (scl_fall) begin
                        next_r.bitcnt = 4'h0;
                        next_r.sda_oe = 1'b0;
                        if (r.rw == `PID_DIR_READ) begin
                            b = read_at(r.ptr); // [RULE3]
                            next_r.sh = b;
                            next_r.sda_oe = ~b[7];
                            next_r.bitcnt = 4'h1;
                            next_r.st = pid_pkg::PID_D_SEND;
                        end else begin
                            next_r.st = pid_pkg::PID_D_WORD;
                        end
                    end
                end
                pid_pkg::PID_D_ACK_WORD: begin
                    // Data writes are not served here; the store goes quiet
                    // and waits for a repeated start or a stop.
                    if (scl_fall) begin
                        next_r.sda_oe = 1'b0;
                        next_r.st = pid_pkg::PID_D_IDLE;
                    end
                end
                pid_pkg::PID_D_SEND: begin
                    if (scl_fall) begin
                        if (r.bitcnt == 4'h8) begin
                            next_r.sda_oe = 1'b0;
                            next_r.ptr = advance(r.ptr); // [RULE5] [RULE7]
                            next_r.byte_done = 1'b1;
                            next_r.st = pid_pkg::PID_D_MACK;
                        end else begin
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.sda_oe = ~r.sh[6];
                            next_r.bitcnt = 4'(r.bitcnt + 4'h1);
                        end
                    end
                end
                pid_pkg::PID_D_MACK: begin
                    if (scl_rise) begin
                        next_r.macked = ~r.sda_f;
                    end else if (scl_fall) begin
                        if (r.macked) begin
                            b = read_at(r.ptr); // [RULE6] [RULE8]
                            next_r.sh = b;
                            next_r.sda_oe = ~b[7];
                            next_r.bitcnt = 4'h1;
                            next_r.st = pid_pkg::PID_D_SEND;
                        end else begin
                            next_r.sda_oe = 1'b0; // [RULE4]
                            next_r.st = pid_pkg::PID_D_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.st = pid_pkg::PID_D_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign link.d_sda_oe = r.sda_oe;
    assign addr_ptr = r.ptr;
    assign byte_done = r.byte_done;
endmodule
`default_nettype wire

// ---- pid_host_master.sv ----
// Bus master that reads the protected identifier, with its receive FIFO.
`default_nettype none
`include "pid_params.svh"

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module pid_fifo #(
    parameter int WIDTH = `PID_FIFO_WIDTH,
    parameter int DEPTH = `PID_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] count;
        logic full;
        logic nempty;
    } pid_fifo_state_t;
    pid_fifo_state_t r;
    pid_fifo_state_t next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic wr;
    logic rd;

    assign wr = in_valid & ~r.full;
    assign rd = out_ready & r.nempty;

    always_comb begin
        next_r = r;
        if (wr) begin
            next_r.wptr = (r.wptr == AW'(DEPTH - 1)) ? '0 : AW'(r.wptr + 1'b1);
        end
        if (rd) begin
            next_r.rptr = (r.rptr == AW'(DEPTH - 1)) ? '0 : AW'(r.rptr + 1'b1);
        end
        next_r.count = CW'(r.count + CW'(wr) - CW'(rd));
        next_r.full = (next_r.count == CW'(DEPTH));
        next_r.nempty = (next_r.count != '0);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clock) begin
        if (wr) begin
            mem[r.wptr] <= in_data;
        end
    end

    assign in_ready = ~r.full;
    assign out_valid = r.nempty;
    assign out_data = mem[r.rptr];
endmodule

// ----------------------------------------------------------------
// Master engine
// ----------------------------------------------------------------
module pid_host_master (
    input wire logic clock,
    input wire logic resetn,
    pid_link_if.mst link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_current,
    input wire logic [7:0] cmd_addr,
    input wire logic [3:0] cmd_count,
    output logic done,
    output logic nack_err,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [7:0] rd_data
);
    localparam logic [3:0] QLAST = 4'(`PID_QUARTER_CYC - 1);
    pid_pkg::pid_mst_t r;
    pid_pkg::pid_mst_t next_r;
    logic fifo_in_ready;

    // Each bit slot has four quarters: low, low (data changes), high, high
    // (sample at end). Changing data only while the clock is low keeps the
    // slave from seeing a false start or stop.
    always_comb begin
        logic [1:0] nq;
        nq = 2'h0;
        next_r = r;
        next_r.done = 1'b0;
        next_r.nack_err = 1'b0;
        next_r.sda_s = {r.sda_s[1:0], link.sda};
        if (r.sda_s[1] == r.sda_s[2]) begin
            next_r.sda_f = r.sda_s[2];
        end
        if (r.push && fifo_in_ready) begin
            next_r.push = 1'b0;
        end
        if (r.st == pid_pkg::PID_M_IDLE) begin
            next_r.scl_oe = 1'b0;
            next_r.sda_oe = 1'b0;
            // Ready follows the idle state, so the first command after reset is taken.
            next_r.cmd_ready = 1'b1;
            if (cmd_valid && r.cmd_ready) begin
                next_r.cmd_ready = 1'b0;
                next_r.addr = cmd_addr;
                next_r.left = (cmd_count == 4'h0) ? 4'h1 : cmd_count;
                next_r.step = cmd_current ? 2'h2 : 2'h0;
                next_r.st = pid_pkg::PID_M_START;
                next_r.q = 2'h0;
                next_r.qc = 4'h0;
                next_r.scl_oe = 1'b1;
            end
        end else if (r.push && !fifo_in_ready) begin
            // A full FIFO holds the clock low at the start of the acknowledge slot.
            next_r.qc = r.qc;
        end else if (r.qc != QLAST) begin
            next_r.qc = 4'(r.qc + 4'h1);
        end else begin
            next_r.qc = 4'h0;
            if (r.q == 2'h3) begin
                case (r.st)
                    pid_pkg::PID_M_START: begin
                        next_r.sh = {`PID_CTRL_CODE, (r.step == 2'h2)};
                        next_r.slot = 4'h0;
                        next_r.st = pid_pkg::PID_M_TX;
                    end
                    pid_pkg::PID_M_TX: begin
                        if (r.slot != 4'h8) begin
                            next_r.sh = {r.sh[6:0], 1'b0};
                            next_r.slot = 4'(r.slot + 4'h1);
                        end else if (r.sda_f) begin
                            next_r.nack_err = 1'b1;
                            next_r.st = pid_pkg::PID_M_STOP;
                        end else if (r.step == 2'h0) begin
                            next_r.sh = r.addr; // [RULE1]
                            next_r.slot = 4'h0;
                            next_r.step = 2'h1;
                        end else if (r.step == 2'h1) begin
                            next_r.step = 2'h2;
                            next_r.st = pid_pkg::PID_M_START; // [RULE2]
                        end else begin
                            next_r.step = 2'h3; // [RULE3]
                            next_r.slot = 4'h0;
                            next_r.st = pid_pkg::PID_M_RX;
                        end
                    end
                    pid_pkg::PID_M_RX: begin
                        if (r.slot != 4'h8) begin
                            next_r.sh = {r.sh[6:0], r.sda_f};
                            next_r.slot = 4'(r.slot + 4'h1);
                            if (r.slot == 4'h7) begin
                                next_r.push = 1'b1;
                                next_r.pdata = {r.sh[6:0], r.sda_f};
                            end
                        end else if (r.left == 4'h1) begin
                            next_r.st = pid_pkg::PID_M_STOP; // [RULE4]
                        end else begin
                            next_r.left = 4'(r.left - 4'h1); // [RULE6]
                            next_r.slot = 4'h0;
                        end
                    end
                    default: begin
                        next_r.st = pid_pkg::PID_M_IDLE;
                        next_r.done = 1'b1;
                        next_r.cmd_ready = 1'b1;
                    end
                endcase
            end
            nq = 2'(r.q + 2'h1);
            next_r.q = nq;
            if (next_r.st != pid_pkg::PID_M_IDLE) begin
                case (nq)
                    2'h0: begin
                        next_r.scl_oe = 1'b1;
                    end
                    2'h1: begin
                        case (next_r.st)
                            pid_pkg::PID_M_START: next_r.sda_oe = 1'b0;
                            pid_pkg::PID_M_STOP: next_r.sda_oe = 1'b1;
                            pid_pkg::PID_M_TX: next_r.sda_oe = (r.slot != 4'h8) & ~r.sh[7];
                            default: next_r.sda_oe = (r.slot == 4'h8) && (r.left != 4'h1);
                        endcase
                    end
                    2'h2: begin
                        next_r.scl_oe = 1'b0;
                    end
                    default: begin
                        if (next_r.st == pid_pkg::PID_M_START) begin
                            next_r.sda_oe = 1'b1;
                        end else if (next_r.st == pid_pkg::PID_M_STOP) begin
                            next_r.sda_oe = 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    pid_fifo #(.WIDTH(`PID_FIFO_WIDTH), .DEPTH(`PID_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_valid(r.push),
        .in_ready(fifo_in_ready),
        .in_data(r.pdata),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

    assign link.m_scl_oe = r.scl_oe;
    assign link.m_sda_oe = r.sda_oe;
    assign cmd_ready = r.cmd_ready;
    assign done = r.done;
    assign nack_err = r.nack_err;
endmodule
`default_nettype wire

// ---- pid_link_sva.sv ----
// Wire-level checker for the identifier link.
`default_nettype none
module pid_link_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic m_scl_oe,
    input wire logic m_sda_oe,
    input wire logic d_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    logic scl_q;
    logic sda_q;
    logic [7:0] cnt;
    // Clock rises since the last start; the start slot's own rise is wiped by the start.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            cnt <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && sda_q && !sda) begin
                cnt <= 8'h00;
            end else if (scl && !scl_q) begin
                cnt <= cnt + 8'h01;
            end
        end
    end
    property p_dev_low; $changed(d_sda_oe) |-> !scl; endproperty
    a_dev_low: assert property (p_dev_low)
        else $error("device moved data while clock high");
    property p_dev_hold; $rose(scl) |=> $stable(d_sda_oe) [*3]; endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("device data not held over clock high");
    property p_no_fight; scl |-> !(m_sda_oe && d_sda_oe); endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive data");
    property p_stop_rel; (scl && $rose(sda)) |-> !d_sda_oe [*8]; endproperty
    a_stop_rel: assert property (p_stop_rel)
        else $error("device drives after stop");
    property p_start_mst; (scl && $fell(sda)) |-> m_sda_oe && !d_sda_oe; endproperty
    a_start_mst: assert property (p_start_mst)
        else $error("start not made by master");
    property p_low4; $fell(scl) |-> !scl [*4]; endproperty
    a_low4: assert property (p_low4)
        else $error("clock low phase too short");
    property p_high4; $rose(scl) |-> scl [*4]; endproperty
    a_high4: assert property (p_high4)
        else $error("clock high phase too short");
    property p_frame; (scl && $rose(sda)) |-> cnt % 8'h09 == 8'h01; endproperty
    a_frame: assert property (p_frame)
        else $error("stop not on a nine-bit boundary");
endmodule
`default_nettype wire

// ---- protected_id_eeprom_read_path_tb.sv ----
// Self-checking bench joining the identifier store and its bus master.
`default_nettype none
module protected_id_eeprom_read_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_current = 1'b0;
    logic [7:0] cmd_addr = 8'hf0;
    logic [3:0] cmd_count = 4'h1;
    logic rd_ready = 1'b0;
    logic cmd_ready, done, nack_err, rd_valid, nack_seen, byte_done;
    logic [7:0] rd_data, addr_ptr;
    int err_count = 0;
    int n_tests = 0;
    int n_sent = 0;
    // The extension opens with a reserved word, so its top byte must read as zero.
    logic [7:0] exp_mem [8] = '{8'h5a, 8'h3c, 8'h1e, 8'h00, 8'hff, 8'h12, 8'h34, 8'h56};
    pid_link_if link();
    pid_id_device #(.ORG_ID(24'h5a3c1e), .EXT_ID(40'hffff123456)) u_pid_id_device (
        .clock(clock), .resetn(resetn), .link(link), .addr_ptr(addr_ptr), .byte_done(byte_done));
    pid_host_master u_pid_host_master (.clock(clock), .resetn(resetn), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_current(cmd_current),
        .cmd_addr(cmd_addr), .cmd_count(cmd_count), .done(done), .nack_err(nack_err),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
    pid_link_sva u_chk (.clock(clock), .resetn(resetn), .m_scl_oe(link.m_scl_oe),
        .m_sda_oe(link.m_sda_oe), .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (nack_err === 1'b1) begin
            nack_seen <= 1'b1;
        end
        if (byte_done === 1'b1) begin
            n_sent <= n_sent + 1;
        end
    end
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // One command: wait idle, hand it over, drain with stalls, then wait for its end.
    task automatic run_cmd(input logic cur, input logic [7:0] addr, input logic [3:0] cnt,
            input logic nack, input int pause);
        int i;
        int k;
        i = 0;
        @(posedge clock);
        while (cmd_ready !== 1'b1 && i < 4000) begin
            @(posedge clock);
            i++;
        end
        check1(cmd_ready, 1'b1);
        cmd_valid <= 1'b1;
        cmd_current <= cur;
        cmd_addr <= addr;
        cmd_count <= cnt;
        nack_seen <= 1'b0;
        n_sent <= 0;
        @(posedge clock);
        cmd_valid <= 1'b0;
        repeat (pause) @(posedge clock);
        for (k = 0; k < (nack ? 0 : int'(cnt)); k++) begin
            i = 0;
            while (rd_valid !== 1'b1 && i < 4000) begin
                @(posedge clock);
                i++;
            end
            check8(rd_data, exp_mem[addr[2:0] + k[2:0]]);
            rd_ready <= 1'b1;
            @(posedge clock);
            rd_ready <= 1'b0;
            repeat (3) @(posedge clock);
        end
        i = 0;
        while (done !== 1'b1 && i < 8000) begin
            @(posedge clock);
            i++;
        end
        check1(done, 1'b1);
        check1(nack_seen, nack);
        check8(8'(n_sent), nack ? 8'h00 : 8'(cnt));
        check1(rd_valid, 1'b0);
    endtask
    task automatic sc_random;
        int a;
        for (a = 0; a < 8; a++) begin
            run_cmd(1'b0, 8'hf0 + 8'(a), 4'h1, 1'b0, 0);
            check8(addr_ptr, 8'hf0 | 8'((a + 1) % 8));
        end
    endtask
    // The pause lets the buffer fill, so the master has to hold the clock.
    task automatic sc_seq_stall;
        run_cmd(1'b0, 8'hf5, 4'ha, 1'b0, 2000);
        check8(addr_ptr, 8'hf7);
    endtask
    task automatic sc_current;
        run_cmd(1'b1, 8'hf7, 4'h2, 1'b0, 0);
        check8(addr_ptr, 8'hf1);
    endtask
    task automatic sc_encap;
        logic [63:0] w;
        w = pid_pkg::pid_encap48(48'h5a3c1e123456);
        check8(w[47:40], 8'h1e);
        check8(w[39:32], 8'hff);
        check8(w[31:24], 8'hfe);
        check8(w[23:16], 8'h12);
    endtask
    task automatic sc_out_of_range;
        run_cmd(1'b0, 8'h20, 4'h1, 1'b1, 0);
        check8(addr_ptr, 8'hf1);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        sc_random();
        sc_seq_stall();
        sc_current();
        sc_out_of_range();
        sc_encap();
        report_and_stop();
    end
    // About 8000 cycles are expected; the limit leaves room for every bounded wait.
    initial begin
        #(25 * 30000);
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
